/* ctl_mode_pkg.sv */
`default_nettype none

// Shared constants and carriers for the control mode and configuration select block.
package ctl_mode_pkg;

    // Serial frame layout: 12 header bits, 4 address bits, 16 data bits.
    localparam int          FRAME_BITS   = 32;           // Bits in one register access.
    localparam logic [11:0] FRAME_HEADER = 12'h001;      // Eleven zeros then a one.
    localparam int          HDR_MSB      = 31;           // Header top bit in the shift word.
    localparam int          HDR_LSB      = 20;           // Header bottom bit.
    localparam int          ADR_MSB      = 19;           // Address top bit.
    localparam int          ADR_LSB      = 16;           // Address bottom bit.
    localparam int          NUM_REGS     = 9;            // Registers reached over the port.

    // Register addresses.
    localparam logic [3:0] ADDR_CALIBRATION       = 4'h0; // Calibration request.
    localparam logic [3:0] ADDR_MAIN_CONFIGURATION = 4'h1; // Main configuration.
    localparam logic [3:0] ADDR_I_OFFSET_TRIM     = 4'h2; // I channel offset.
    localparam logic [3:0] ADDR_I_FULL_SCALE_TRIM = 4'h3; // I channel full scale.
    localparam logic [3:0] ADDR_EXT_CONFIGURATION = 4'h9; // Extended configuration.
    localparam logic [3:0] ADDR_Q_OFFSET_TRIM     = 4'ha; // Q channel offset.
    localparam logic [3:0] ADDR_Q_FULL_SCALE_TRIM = 4'hb; // Q channel full scale.
    localparam logic [3:0] ADDR_SAMPLE_PHASE_FINE = 4'he; // Fine sample clock phase.
    localparam logic [3:0] ADDR_SAMPLE_PHASE_CM   = 4'hf; // Coarse and intermediate phase.

    // Power-on values of the registers.
    localparam logic [15:0] RST_CALIBRATION       = 16'h7fff; // No calibration request.
    localparam logic [15:0] RST_MAIN_CONFIGURATION = 16'hb2ff; // DDR, 0 deg, high swing, demux.
    localparam logic [15:0] RST_OFFSET_TRIM       = 16'h007f; // Zero offset adjustment.
    localparam logic [15:0] RST_FULL_SCALE_TRIM   = 16'h807f; // Mid code, nominal range.
    localparam logic [15:0] RST_EXT_CONFIGURATION = 16'h007f; // No pattern, trim on, no DES.
    localparam logic [15:0] RST_SAMPLE_PHASE_FINE = 16'h00ff; // No fine adjustment.
    localparam logic [15:0] RST_SAMPLE_PHASE_CM   = 16'h007f; // No coarse or mid adjustment.

    // Field positions.
    localparam int CAL_BIT          = 15; // Calibration request bit.
    localparam int SECOND_CLK_N_BIT = 13; // Second output clock enable, low active.
    localparam int PHASE_SEL_BIT    = 11; // Double-rate clock phase select.
    localparam int RATE_SEL_BIT     = 10; // Data-rate select, low means double rate.
    localparam int SWING_SEL_BIT    = 9;  // Output swing select.
    localparam int EDGE_DEMUX_BIT   = 8;  // Data edge or demultiplex select.
    localparam int TEST_PAT_BIT     = 15; // Test pattern enable.
    localparam int TRIM_DIS_BIT     = 14; // Trim disable, output clock always present.
    localparam int DES_EN_BIT       = 13; // Dual-edge sampling enable.
    localparam int DES_Q_BIT        = 12; // Dual-edge sampling input select, 1 picks Q.
    localparam int TRIM_MSB         = 15; // Top of the 9-bit trim fields.
    localparam int TRIM_LSB         = 7;  // Bottom of the 9-bit trim fields.
    localparam int FINE_MSB         = 15; // Top of the fine phase field.
    localparam int FINE_LSB         = 8;  // Bottom of the fine phase field.

    // Strap-mode full-scale codes, used when the range comes from the strap.
    localparam logic [8:0] FS_STRAP_NORMAL  = 9'h100; // Normal range.
    localparam logic [8:0] FS_STRAP_REDUCED = 9'h000; // Reduced range.

    // Cycles after reset release before the strap mode is taken.
    localparam logic [1:0] STRAP_SETTLE = 2'h3;

    // A pin that may float: its sensed level and a float flag.
    typedef struct packed {
        logic level; // Sensed level when driven.
        logic float; // High while nothing drives the pin.
    } tri_pin_type;

    // One consistent configuration handed downstream.
    typedef struct packed {
        logic       extended;         // Extended control in force.
        logic       single_rate;      // Single data rate output clocking.
        logic       ddr_phase_90;     // Double-rate clock at 90 degrees.
        logic       data_edge_rise;   // Single-rate data changes on rising edge.
        logic       demux_1to2;       // Double-rate output demultiplexed 1:2.
        logic       swing_normal;     // Normal output swing.
        logic       cal_delay_long;   // Long power-on calibration delay.
        logic [8:0] full_scale_i;     // I channel full-scale code.
        logic [8:0] full_scale_q;     // Q channel full-scale code.
        logic       offset_enable;    // Offset trim applied.
        logic [8:0] offset_i;         // I channel offset code.
        logic [8:0] offset_q;         // Q channel offset code.
        logic       des_enable;       // Dual-edge sampling on.
        logic       des_select_q;     // Dual-edge sampling takes Q input.
        logic       test_pattern;     // Test pattern drives data outputs.
        logic       clock_continuous; // Output clock always present.
        logic       second_clock;     // Out-of-range pair carries output clock.
        logic [8:0] phase_coarse_mid; // Coarse and intermediate phase steps.
        logic [7:0] phase_fine;       // Fine phase steps.
    } cfg_type;

endpackage

`default_nettype wire

/* control_mode_config_select.sv */
// Function
// - Mode pin low selects extended control.
// - Full-scale pin may enable extended when mode floats.
// - Extended mode exposes nine serial registers.
// - Data rate from strap or bit 10.
// - Clock phase zero, or bit 11 extended.
// - Standard single-rate edge follows edge strap.
// - Bit 8 picks edge, or demux in double-rate.
// - Swing from strap, or swing bit extended.
// - Calibration delay from strap; extended always short.
// - Full scale shared strap, or per-channel bits 15:7.
// - Offset trim only extended, bits 15:7 per channel.
// - Dual-edge sampling: floating delay strap, or bit 13.
// - Test pattern from bit 15, extended only.
// - Trim disable keeps output clock present, extended only.
// - Second clock on out-of-range pair when bit 13 low.
// - Sample phase coarse/mid and fine from registers.
// - Registers load defaults on power-on reset.
// - Defaults: double rate, 0 deg, high swing, short delay.
// - Defaults: nominal range, no offset, no DES, no pattern.
// - Defaults: trim on, demux 1:2, out-of-range, zero phase.
// - Registers have no effect in standard mode.
// - Demux meaning of bit 8 only in double rate.
`default_nettype none

module control_mode_config_select (
    input  wire logic                      clk_sys,      // System clock, 250 MHz.
    input  wire logic                      nrst,         // Power-on reset, low active.
    input  wire ctl_mode_pkg::tri_pin_type mode_pin,     // Primary control mode pin.
    input  wire ctl_mode_pkg::tri_pin_type mode_alt_pin, // Secondary mode qualifying pin.
    input  wire ctl_mode_pkg::tri_pin_type fs_pin,       // Full-scale strap, also mode pin.
    input  wire ctl_mode_pkg::tri_pin_type rate_pin,     // Edge strap; floating means DDR.
    input  wire ctl_mode_pkg::tri_pin_type delay_pin,    // Cal delay strap; floating means DES.
    input  wire logic                      swing_pin,    // Output swing strap.
    input  wire logic                      sclk,         // Serial clock from host.
    input  wire logic                      sdata,        // Serial data from host.
    input  wire logic                      scs_n,        // Serial chip select, low active.
    output var  ctl_mode_pkg::cfg_type     cfg_q,        // Selected configuration.
    output logic                           cal_req_q,    // One-cycle calibration request.
    output logic                           mode_valid_q  // Strap mode has been latched.
);
    import ctl_mode_pkg::*;

    // Two-stage synchronisers for every pin; stage one feeds only stage two.
    logic [13:0] pin_meta_q;   // First synchroniser stage.
    logic [13:0] pin_sync_q;   // Second synchroniser stage, safe to read.
    logic        sclk_prev_q;  // Last synchronised serial clock for edge finding.

    // Strap mode capture.
    logic [1:0]  settle_q;     // Counts cycles after reset release.
    logic        ext_mode_q;   // Latched extended control mode.
    logic        ext_mode_d;   // Mode decoded from synchronised pins.

    // Serial receiver.
    logic [31:0] shift_q;      // Incoming frame, newest bit at bit 0.
    logic [4:0]  bit_cnt_q;    // Bits of the current frame taken so far.
    logic [31:0] shift_d;      // Shift word including the bit now arriving.
    logic        sclk_rise;    // Rising serial clock edge seen this cycle.
    logic        frame_done;   // Thirty-second bit arriving this cycle.
    logic        frame_ok;     // Completed frame carries a good header.

    // Register file.
    logic [15:0] reg_main_q;   // Main configuration register.
    logic [15:0] reg_ioff_q;   // I offset trim register.
    logic [15:0] reg_ifs_q;    // I full-scale trim register.
    logic [15:0] reg_ext_q;    // Extended configuration register.
    logic [15:0] reg_qoff_q;   // Q offset trim register.
    logic [15:0] reg_qfs_q;    // Q full-scale trim register.
    logic [15:0] reg_fine_q;   // Fine sample phase register.
    logic [15:0] reg_cm_q;     // Coarse and intermediate sample phase register.

    // Synchronised views of the pins.
    tri_pin_type mode_s;       // Primary mode pin.
    tri_pin_type alt_s;        // Secondary mode pin.
    tri_pin_type fs_s;         // Full-scale pin.
    tri_pin_type rate_s;       // Edge and rate strap.
    tri_pin_type delay_s;      // Delay and DES strap.
    logic        swing_s;      // Swing strap.
    logic        sclk_s;       // Serial clock.
    logic        sdata_s;      // Serial data.
    logic        scs_n_s;      // Serial chip select.

    // Configuration candidates.
    cfg_type     strap_cfg;    // Configuration built from straps.
    cfg_type     reg_cfg;      // Configuration built from registers.
    cfg_type     cfg_d;        // Configuration chosen by mode.

    // All pins pass two flops because the host drives them from its own timing.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            // Chip select rests high in both stages, so no frame opens at release.
            pin_meta_q <= 14'h2000;
            pin_sync_q <= 14'h2000;
        end else begin
            pin_meta_q <= {scs_n, sdata, sclk, swing_pin, delay_pin, rate_pin,
                           fs_pin, mode_alt_pin, mode_pin};
            pin_sync_q <= pin_meta_q;
        end
    end

    // Unpack the synchronised pins.
    assign mode_s  = pin_sync_q[1:0];
    assign alt_s   = pin_sync_q[3:2];
    assign fs_s    = pin_sync_q[5:4];
    assign rate_s  = pin_sync_q[7:6];
    assign delay_s = pin_sync_q[9:8];
    assign swing_s = pin_sync_q[10];
    assign sclk_s  = pin_sync_q[11];
    assign sdata_s = pin_sync_q[12];
    assign scs_n_s = pin_sync_q[13];

    // Mode decode from the strap pins.
    always_comb begin
        ext_mode_d = 1'b0;
        if (!mode_s.float) begin
            ext_mode_d = !mode_s.level;
        end else if (alt_s.float || alt_s.level) begin
            ext_mode_d = fs_s.float;
        end
    end

    // Strap mode is caught once the synchronisers have filled after reset.
    // The host keeps it fixed, so it is taken once and never re-read.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            settle_q     <= 2'h0;
            ext_mode_q   <= 1'b0;
            mode_valid_q <= 1'b0;
        end else if (!mode_valid_q) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == STRAP_SETTLE) begin
                ext_mode_q   <= ext_mode_d;
                mode_valid_q <= 1'b1;
            end
        end
    end

    // Serial clock edge and frame assembly; data is taken on the rising edge.
    assign sclk_rise  = sclk_s && !sclk_prev_q;
    assign shift_d    = {shift_q[30:0], sdata_s};
    assign frame_done = sclk_rise && !scs_n_s && (bit_cnt_q == 5'(FRAME_BITS - 1));
    assign frame_ok   = (shift_d[HDR_MSB:HDR_LSB] == FRAME_HEADER);

    // The port listens only in extended mode; chip select high restarts a frame.
    // A frame may follow the last at once, starting on the thirty-third clock.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sclk_prev_q <= 1'b0;
            shift_q     <= 32'h0000_0000;
            bit_cnt_q   <= 5'h00;
        end else begin
            sclk_prev_q <= sclk_s;
            if (scs_n_s || !ext_mode_q) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_rise) begin
                shift_q   <= shift_d;
                bit_cnt_q <= bit_cnt_q + 5'h01;
            end
        end
    end

    // Register writes; reset loads the extended-mode defaults with no host action.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_main_q <= RST_MAIN_CONFIGURATION;
            reg_ioff_q <= RST_OFFSET_TRIM;
            reg_ifs_q  <= RST_FULL_SCALE_TRIM;
            reg_ext_q  <= RST_EXT_CONFIGURATION;
            reg_qoff_q <= RST_OFFSET_TRIM;
            reg_qfs_q  <= RST_FULL_SCALE_TRIM;
            reg_fine_q <= RST_SAMPLE_PHASE_FINE;
            reg_cm_q   <= RST_SAMPLE_PHASE_CM;
        end else if (frame_done && frame_ok) begin
            case (shift_d[ADR_MSB:ADR_LSB])
                ADDR_MAIN_CONFIGURATION: reg_main_q <= shift_d[15:0];
                ADDR_I_OFFSET_TRIM:      reg_ioff_q <= shift_d[15:0];
                ADDR_I_FULL_SCALE_TRIM:  reg_ifs_q  <= shift_d[15:0];
                ADDR_EXT_CONFIGURATION:  reg_ext_q  <= shift_d[15:0];
                ADDR_Q_OFFSET_TRIM:      reg_qoff_q <= shift_d[15:0];
                ADDR_Q_FULL_SCALE_TRIM:  reg_qfs_q  <= shift_d[15:0];
                ADDR_SAMPLE_PHASE_FINE:  reg_fine_q <= shift_d[15:0];
                ADDR_SAMPLE_PHASE_CM:    reg_cm_q   <= shift_d[15:0];
                default: begin
                    // Calibration and reserved addresses store nothing.
                end
            endcase
        end
    end

    // A write of the calibration bit gives one request pulse; it stores nothing.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cal_req_q <= 1'b0;
        end else begin
            cal_req_q <= frame_done && frame_ok && shift_d[CAL_BIT]
                         && (shift_d[ADR_MSB:ADR_LSB] == ADDR_CALIBRATION);
        end
    end

    // Strap-derived configuration; options without a strap stay off, except 1:2 demux, which is on.
    always_comb begin
        strap_cfg                  = '0;
        strap_cfg.single_rate      = !rate_s.float;
        strap_cfg.ddr_phase_90     = 1'b0;
        strap_cfg.data_edge_rise   = rate_s.level;
        strap_cfg.demux_1to2       = 1'b1;
        strap_cfg.swing_normal     = swing_s;
        strap_cfg.cal_delay_long   = !delay_s.float && delay_s.level;
        strap_cfg.full_scale_i     = fs_s.level ? FS_STRAP_NORMAL : FS_STRAP_REDUCED;
        strap_cfg.full_scale_q     = strap_cfg.full_scale_i;
        strap_cfg.offset_enable    = 1'b0;
        strap_cfg.des_enable       = delay_s.float;
        strap_cfg.des_select_q     = 1'b0;
        strap_cfg.test_pattern     = 1'b0;
        strap_cfg.clock_continuous = 1'b0;
        strap_cfg.second_clock     = 1'b0;
    end

    // Register-derived configuration for extended mode.
    always_comb begin
        reg_cfg                  = '0;
        reg_cfg.extended         = 1'b1;
        reg_cfg.single_rate      = reg_main_q[RATE_SEL_BIT];
        reg_cfg.ddr_phase_90     = reg_main_q[PHASE_SEL_BIT];
        // Bit 8 is the edge in single rate and the demux choice in double rate.
        reg_cfg.data_edge_rise   = reg_main_q[EDGE_DEMUX_BIT];
        reg_cfg.demux_1to2       = !reg_main_q[RATE_SEL_BIT]
                                   && !reg_main_q[EDGE_DEMUX_BIT];
        reg_cfg.swing_normal     = reg_main_q[SWING_SEL_BIT];
        reg_cfg.cal_delay_long   = 1'b0;
        reg_cfg.full_scale_i     = reg_ifs_q[TRIM_MSB:TRIM_LSB];
        reg_cfg.full_scale_q     = reg_qfs_q[TRIM_MSB:TRIM_LSB];
        reg_cfg.offset_enable    = 1'b1;
        reg_cfg.offset_i         = reg_ioff_q[TRIM_MSB:TRIM_LSB];
        reg_cfg.offset_q         = reg_qoff_q[TRIM_MSB:TRIM_LSB];
        reg_cfg.des_enable       = reg_ext_q[DES_EN_BIT];
        reg_cfg.des_select_q     = reg_ext_q[DES_Q_BIT];
        reg_cfg.test_pattern     = reg_ext_q[TEST_PAT_BIT];
        reg_cfg.clock_continuous = reg_ext_q[TRIM_DIS_BIT];
        reg_cfg.second_clock     = !reg_main_q[SECOND_CLK_N_BIT];
        reg_cfg.phase_coarse_mid = reg_cm_q[TRIM_MSB:TRIM_LSB];
        reg_cfg.phase_fine       = reg_fine_q[FINE_MSB:FINE_LSB];
    end

    // One mux picks a whole configuration, so no feature mixes the two sources.
    // Register values cannot leak through while standard mode is latched.
    assign cfg_d = ext_mode_q ? reg_cfg : strap_cfg;

    // Output register; reset and the wait for the strap mode hold every field at zero.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cfg_q <= '0;
        end else if (!mode_valid_q) begin
            cfg_q <= '0;
        end else begin
            cfg_q <= cfg_d;
        end
    end

endmodule

`default_nettype wire

/* control_mode_config_select_monitor.sv */
`default_nettype none
// Port checks; all properties sample on clk_sys and rest while reset is low.
module control_mode_config_select_monitor (
    input wire logic                      clk_sys,      // Clock.
    input wire logic                      nrst,         // Reset, low active.
    input wire ctl_mode_pkg::tri_pin_type mode_pin,     // Mode strap.
    input wire ctl_mode_pkg::tri_pin_type mode_alt_pin, // Second mode strap.
    input wire ctl_mode_pkg::tri_pin_type fs_pin,       // Full-scale strap.
    input wire ctl_mode_pkg::tri_pin_type delay_pin,    // Delay strap.
    input wire logic                      swing_pin,    // Swing strap.
    input wire ctl_mode_pkg::cfg_type     cfg_q,        // Configuration.
    input wire logic                      cal_req_q,    // Calibration pulse.
    input wire logic                      mode_valid_q  // Mode latched.
);
    import ctl_mode_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    logic want_ext; // Mode the straps call for; a floating mode pin defers to fs_pin unless mode_alt_pin is driven low.
    assign want_ext = (!mode_pin.float && !mode_pin.level) || (mode_pin.float
        && (mode_alt_pin.float || mode_alt_pin.level) && fs_pin.float);
    // The valid flag rises, and the configuration settles one cycle later.
    sequence latch_s;
        !mode_valid_q ##1 mode_valid_q ##1 1'b1;
    endsequence
    valid_bound_a: assert property ($rose(nrst) |-> ##[1:8] mode_valid_q)
        else $error("mode not latched");
    zero_early_a: assert property (!mode_valid_q |-> cfg_q == '0)
        else $error("config before latch");
    mode_pick_a: assert property (latch_s |-> cfg_q.extended == want_ext)
        else $error("wrong mode");
    std_strap_a: assert property (latch_s ##0 !cfg_q.extended |->
        cfg_q.swing_normal == swing_pin && cfg_q.des_enable == delay_pin.float
        && cfg_q.full_scale_i == (fs_pin.level ? FS_STRAP_NORMAL : FS_STRAP_REDUCED))
        else $error("strap not passed on");
    std_none_a: assert property (!cfg_q.extended |-> !(cfg_q.test_pattern
        || cfg_q.clock_continuous || cfg_q.second_clock || cfg_q.offset_enable))
        else $error("extended feature in standard mode");
    ext_delay_a: assert property (cfg_q.extended |-> !cfg_q.cal_delay_long)
        else $error("long delay in extended mode");
    demux_sdr_a: assert property (cfg_q.extended && cfg_q.single_rate |->
        !cfg_q.demux_1to2) else $error("demux in single rate");
    ext_dflt_a: assert property (latch_s ##0 cfg_q.extended |-> !cfg_q.single_rate
        && !cfg_q.ddr_phase_90 && cfg_q.swing_normal && cfg_q.demux_1to2)
        else $error("extended defaults");
    trim_dflt_a: assert property (latch_s ##0 cfg_q.extended |->
        cfg_q.full_scale_i == 9'h100 && cfg_q.full_scale_q == 9'h100 && !cfg_q.des_enable
        && {cfg_q.offset_i, cfg_q.offset_q, cfg_q.phase_fine, cfg_q.phase_coarse_mid} == '0
        && !cfg_q.test_pattern && !cfg_q.clock_continuous && !cfg_q.second_clock)
        else $error("trim defaults");
    cal_pulse_a: assert property (cal_req_q |-> cfg_q.extended ##1 !cal_req_q)
        else $error("calibration pulse");
endmodule
`default_nettype wire

/* host_ctrl_model.sv */
`default_nettype none
// Host side of the serial port; its clock stands still between frames.
module host_ctrl_model (
    input  wire logic clk_sys, // Pacing clock.
    output logic      sclk,    // Serial clock, 64 ns period.
    output logic      sdata,   // Serial data, top bit first.
    output logic      scs_n    // Select, low active.
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        scs_n = 1'b1;
    end
    // Shifts the top n bits of w; keep holds select low for a following frame.
    task automatic frame(input logic [31:0] w, input int n, input bit keep);
        @(posedge clk_sys);
        #1 scs_n = 1'b0;
        for (int i = 31; i > 31 - n; i--) begin
            sdata = w[i];
            repeat (8) @(posedge clk_sys);
            #1 sclk = 1'b1;
            repeat (8) @(posedge clk_sys);
            #1 sclk = 1'b0;
        end
        // The data line is released; show the inverse so no stale bit can pass.
        sdata = ~sdata;
        if (!keep) scs_n = 1'b1;
    endtask
endmodule
`default_nettype wire

/* control_mode_config_select_tb.sv */
`default_nettype none
// Random strap sets, each under a fresh reset, then serial writes and refused frames.
module control_mode_config_select_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ctl_mode_pkg::*;
    logic        clk_sys, nrst, swing_pin, sclk, sdata, scs_n, cal_req_q, mode_valid_q;
    tri_pin_type mode_pin, mode_alt_pin, fs_pin, rate_pin, delay_pin; // Straps.
    cfg_type     cfg_q;        // Output under test.
    logic [15:0] r [16];       // Expected register contents.
    logic [3:0]  ad [8] = '{4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf}; // Real ones.
    logic        ext;          // Extended control expected.
    int          n_errors = 0; // Mismatches.
    int          compares = 0; // Comparisons.
    control_mode_config_select dut_u (.*);
    host_ctrl_model host_u (.*);
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    task automatic chk(input bit ok, input string what);
        compares++;
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, what);
        end
    endtask
    task automatic give_verdict();
        if (n_errors == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Configuration that the straps or the written registers call for.
    function automatic cfg_type exp_cfg();
        logic [8:0] fs;
        fs = fs_pin.level ? FS_STRAP_NORMAL : FS_STRAP_REDUCED;
        if (ext) return '{1'b1, r[1][10], r[1][11], r[1][8], !r[1][10] && !r[1][8],
            r[1][9], 1'b0, r[3][15:7], r[11][15:7], 1'b1, r[2][15:7], r[10][15:7],
            r[9][13], r[9][12], r[9][15], r[9][14], !r[1][13], r[15][15:7], r[14][15:8]};
        return '{1'b0, !rate_pin.float, 1'b0, rate_pin.level, 1'b1, swing_pin,
            delay_pin.level, fs, fs, 1'b0, 9'h0, 9'h0, delay_pin.float,
            1'b0, 1'b0, 1'b0, 1'b0, 9'h0, 8'h0};
    endfunction
    // Fields with no meaning in the current rate or strap state are not compared.
    task automatic cmp_cfg(input string what);
        cfg_type e, g;
        e = exp_cfg();
        g = cfg_q;
        if (e.single_rate) g.ddr_phase_90 = e.ddr_phase_90;
        else g.data_edge_rise = e.data_edge_rise;
        if (!ext && delay_pin.float) g.cal_delay_long = e.cal_delay_long;
        chk(g === e, what);
    endtask
    // Only whole frames with the right header to a real register are stored.
    task automatic wr(input logic [31:0] w, input int n, input bit keep);
        host_u.frame(w, n, keep);
        if (ext && n == 32 && w[31:20] == FRAME_HEADER && w[19:16] inside {ad})
            r[w[19:16]] = w[15:0];
        repeat (2) @(posedge clk_sys);
        #1;
    endtask
    task automatic cal(input logic [15:0] d, input int want);
        int seen;
        seen = 0;
        fork
            host_u.frame({FRAME_HEADER, ADDR_CALIBRATION, d}, 32, 1'b0);
            repeat (600) begin
                @(posedge clk_sys);
                #1 seen += int'(cal_req_q === 1'b1);
            end
        join
        chk(seen == want, "calibration pulses");
    endtask
    // Strap sets 0 and 2 ask for extended control, the rest for standard control.
    initial begin
        logic [15:0] d;
        int          k;
        void'($urandom(72));
        for (int i = 0; i < 8; i++) begin
            k = (i < 5) ? i : int'($urandom % 5);
            ext = (k == 0 || k == 2);
            nrst = 1'b0;
            {rate_pin, delay_pin, swing_pin} = 5'($urandom);
            mode_pin = (k == 0) ? 2'b00 : (k == 1) ? 2'b10 : 2'b01;
            mode_alt_pin = (k == 4) ? 2'b00 : {1'b1, 1'($urandom)};
            fs_pin = (k == 2) ? 2'b01 : {1'($urandom), 1'b0};
            r = '{1: RST_MAIN_CONFIGURATION, 3: RST_FULL_SCALE_TRIM, 9: RST_EXT_CONFIGURATION,
                11: RST_FULL_SCALE_TRIM, 14: RST_SAMPLE_PHASE_FINE, 15: RST_SAMPLE_PHASE_CM,
                default: RST_OFFSET_TRIM};
            repeat (6) @(posedge clk_sys);
            #1 nrst = 1'b1;
            for (int t = 0; t < 20 && mode_valid_q !== 1'b1; t++) begin
                @(posedge clk_sys);
                #1;
            end
            if (mode_valid_q !== 1'b1) begin
                chk(1'b0, "mode never latched");
                give_verdict();
            end
            repeat (2) @(posedge clk_sys);
            #1 cmp_cfg("after reset");
            foreach (ad[j]) begin
                d = 16'($urandom);
                if (ad[j] == 4'h1) d = {2'b10, d[13], 1'b1, d[11:8], 8'hff};
                else d[6:0] = r[ad[j]][6:0];
                wr({FRAME_HEADER, ad[j], d}, 32, j[0]);
                cmp_cfg("register write");
            end
            for (int m = 0; m < 4; m++) begin
                d = 16'($urandom);
                wr({FRAME_HEADER, 4'h1, 2'b10, d[13], 1'b1, d[11], m[1], d[9], m[0], 8'hff},
                    32, 1'b0);
                cmp_cfg("rate and edge");
            end
            d = r[1] ^ 16'h2f00;
            wr({12'h003, 4'h1, d}, 32, 1'b0);
            wr({FRAME_HEADER, 4'h4, d}, 32, 1'b0);
            wr({FRAME_HEADER, 4'hc, d}, 32, 1'b0);
            wr({FRAME_HEADER, 4'h1, d}, 20, 1'b0);
            cmp_cfg("refused frames");
            cal(16'hffff, int'(ext));
            cal(16'h7fff, 0);
        end
        give_verdict();
    end
endmodule
bind control_mode_config_select control_mode_config_select_monitor mon_u (.*);
`default_nettype wire
